// ### core/gdfc_pkg.sv
package gdfc_pkg;

    // Word geometry of the serial frame and of every register.
    localparam int GDFC_DATA_W     = 11;
    localparam int GDFC_FRAME_BITS = 16;
    localparam int GDFC_CMD_BITS   = 5;
    localparam int GDFC_COUNT_W    = 5;
    localparam int GDFC_NUM_FETS   = 6;
    localparam int GDFC_NUM_SENSE  = 3;
    localparam int GDFC_IMAGE_W    = 3 * GDFC_DATA_W;

    // Frame bit positions.
    localparam int BIT_FRAME_READ = 15;
    localparam int BIT_ADDR_HI    = 14;
    localparam int BIT_ADDR_LO    = 11;

    // Register addresses.
    localparam logic [3:0] ADDR_FAULT_PRIMARY   = 4'h0;
    localparam logic [3:0] ADDR_FAULT_SECONDARY = 4'h1;
    localparam logic [3:0] ADDR_DRIVE_SETUP     = 4'h2;
    localparam logic [3:0] ADDR_LOCK_SETUP      = 4'h3;

    // Fields of the primary fault word.
    localparam int BIT_FAULT_SUMMARY = 10;
    localparam int BIT_DS_OCP        = 9;
    localparam int BIT_GATE_FAILURE  = 8;
    localparam int BIT_SUPPLY_SUPPLY_UNDERVOLTAGE_LOCKOUT   = 7;
    localparam int BIT_OVERTEMP_SHUTDOWN          = 6;

    // Fields of the secondary fault word.
    localparam int BIT_SENSE_LO      = 8;
    localparam int BIT_OTW           = 7;
    localparam int BIT_PUMP_UV       = 6;

    // Fields of the driver control word.
    localparam int BIT_PUMP_UV_DIS   = 9;
    localparam int BIT_GATE_DIS      = 8;
    localparam int BIT_OTW_REPORT    = 7;
    localparam int BIT_MODE_HI       = 6;
    localparam int BIT_MODE_LO       = 5;
    localparam int BIT_RECTIFY       = 4;
    localparam int BIT_DIRECTION     = 3;
    localparam int BIT_COAST         = 2;
    localparam int BIT_BRAKE         = 1;
    localparam int BIT_CLEAR         = 0;

    // Lock field inside the lock word.
    localparam int BIT_LOCK_HI       = 10;
    localparam int BIT_LOCK_LO       = 8;

    // Values after reset and lock codes.
    localparam logic [10:0] STATUS_RESET      = 11'h000;
    localparam logic [10:0] DRIVE_SETUP_RESET = 11'h000;
    localparam logic [10:0] LOCKED_WRITE_MASK = 11'h007;
    localparam logic [2:0]  LOCK_RESET        = 3'h3;
    localparam logic [2:0]  LOCK_ENGAGE       = 3'h6;
    localparam logic [2:0]  LOCK_RELEASE      = 3'h3;

    // PWM input schemes.
    localparam logic [1:0] MODE_SIX_INPUT    = 2'h0;
    localparam logic [1:0] MODE_THREE_INPUT  = 2'h1;
    localparam logic [1:0] MODE_SINGLE_INPUT = 2'h2;
    localparam logic [1:0] MODE_INDEPENDENT  = 2'h3;

endpackage : gdfc_pkg

// ### core/gdfc_sync.sv
`timescale 1ns/1ps
module gdfc_sync
    import gdfc_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } gdfc_sync_state_t;

    gdfc_sync_state_t cur;
    gdfc_sync_state_t next_cur;

    // The first stage feeds only the second stage.
    always_comb begin
        next_cur.stage1 = async_in;
        next_cur.stage2 = cur.stage1;
    end

    // Both stages clear to zero under reset.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign sync_out = cur.stage2;

endmodule : gdfc_sync

// ### core/gdfc_spi_link.sv
`timescale 1ns/1ps
module gdfc_spi_link
    import gdfc_pkg::*;
(
    input  wire logic                    sclk,
    input  wire logic                    rst_b,
    input  wire logic                    scs_n,
    input  wire logic                    sdi,
    output logic                         sdo,
    output logic                         sdo_oe_n,
    input  wire logic [GDFC_IMAGE_W-1:0] reg_image,
    output logic      [15:0]             frame_word,
    output logic                         frame_ok,
    output logic                         frame_tag
);

    typedef struct packed {
        logic [GDFC_COUNT_W-1:0] count;
        logic [15:0]             shift;
        logic [3:0]              addr;
    } gdfc_frame_state_t;

    typedef struct packed {
        logic [15:0] word;
        logic        ok;
        logic        tag;
    } gdfc_result_state_t;

    gdfc_frame_state_t  frm;
    gdfc_frame_state_t  next_frm;
    gdfc_result_state_t res;
    gdfc_result_state_t next_res;
    logic               out_bit;
    logic               next_out_bit;
    logic               frame_rst_b;
    logic [10:0]        sel_data;
    logic [3:0]         bit_idx;

    // The bit counter starts afresh whenever the select is high.
    assign frame_rst_b = rst_b & ~scs_n;

    // Bits are taken on the falling edge; a count past sixteen marks an error.
    always_comb begin
        next_frm       = frm;
        next_frm.shift = {frm.shift[14:0], sdi};
        if (frm.count <= GDFC_COUNT_W'(GDFC_FRAME_BITS)) begin
            next_frm.count = frm.count + 5'h01;
        end
        if (frm.count == 5'h04) begin
            next_frm.addr = {frm.shift[2:0], sdi};
        end
        next_res      = res;
        next_res.word = next_frm.shift;
        next_res.ok   = (next_frm.count == GDFC_COUNT_W'(GDFC_FRAME_BITS));
        if (frm.count == 5'h00) begin
            next_res.tag = ~res.tag;
        end
    end

    always_ff @(negedge sclk or negedge frame_rst_b) begin
        if (!frame_rst_b) begin
            frm <= '0;
        end else begin
            frm <= next_frm;
        end
    end

    // Results outlive the frame so the system clock can take them later.
    always_ff @(negedge sclk or negedge rst_b) begin
        if (!rst_b) begin
            res <= '0;
        end else begin
            res <= next_res;
        end
    end

    // Five leading zeros, then the addressed word, moved on the rising edge.
    always_comb begin
        case (frm.addr)
            ADDR_FAULT_PRIMARY:   sel_data = reg_image[10:0];
            ADDR_FAULT_SECONDARY: sel_data = reg_image[21:11];
            ADDR_DRIVE_SETUP:     sel_data = reg_image[32:22];
            default:              sel_data = 11'h000;
        endcase
        bit_idx      = 4'(5'h0F - frm.count);
        next_out_bit = 1'b0;
        if (frm.count >= 5'h05 && frm.count < 5'h10) begin
            next_out_bit = sel_data[bit_idx];
        end
    end

    always_ff @(posedge sclk or negedge frame_rst_b) begin
        if (!frame_rst_b) begin
            out_bit <= 1'b0;
        end else begin
            out_bit <= next_out_bit;
        end
    end

    assign sdo        = out_bit;
    assign sdo_oe_n   = scs_n;
    assign frame_word = res.word;
    assign frame_ok   = res.ok;
    assign frame_tag  = res.tag;

endmodule : gdfc_spi_link

// ### core/gdfc_regs.sv
`timescale 1ns/1ps
module gdfc_regs
    import gdfc_pkg::*;
(
    input  wire logic                      clk,
    input  wire logic                      rst_b,
    input  wire logic                      sclk,
    input  wire logic                      scs_n,
    input  wire logic                      sdi,
    output logic                           sdo,
    output logic                           sdo_oe_n,
    input  wire logic                      phase_c_high_input,
    input  wire logic                      phase_c_low_input,
    input  wire logic [GDFC_NUM_FETS-1:0]  drain_source_overcurrent_in,
    input  wire logic [GDFC_NUM_FETS-1:0]  gate_drive_failure_in,
    input  wire logic [GDFC_NUM_SENSE-1:0] sense_amp_overcurrent_in,
    input  wire logic                      overtemp_shutdown_in,
    input  wire logic                      overtemp_warning_in,
    input  wire logic                      charge_pump_undervoltage_in,
    input  wire logic                      supply_undervoltage_lockout_in,
    input  wire logic                      sleep_in,
    output logic                           alarm_out_n,
    output logic                           gates_off,
    output logic                           low_side_brake,
    output logic                           rotate_direction,
    output logic                           async_freewheel,
    output logic [1:0]                     pwm_scheme
);

    localparam int SYNC_W = 2 + 2 + 2 * GDFC_NUM_FETS + GDFC_NUM_SENSE + 5;

    typedef struct packed {
        logic [GDFC_NUM_FETS-1:0]  ds_flags;
        logic [GDFC_NUM_FETS-1:0]  gs_flags;
        logic [GDFC_NUM_SENSE-1:0] sa_flags;
        logic                      overtemp_shutdown;
        logic                      overtemp_warning;
        logic                      pump_uv;
        logic                      supply_uv;
        logic                      summary;
        logic [10:0]               setup;
        logic [2:0]                lock;
        logic [GDFC_IMAGE_W-1:0]   snapshot;
        logic                      scs_prev;
        logic                      tag_seen;
        logic                      alarm_n;
        logic                      gates_off;
        logic                      brake;
        logic                      direction;
        logic                      freewheel;
        logic [1:0]                scheme;
    } gdfc_regs_state_t;

    gdfc_regs_state_t cur;
    gdfc_regs_state_t next_cur;

    logic [SYNC_W-1:0]         raw_in;
    logic [SYNC_W-1:0]         syn;
    logic                      scs_s;
    logic                      tag_s;
    logic                      phase_c_high_input_s;
    logic                      phase_c_low_input_s;
    logic [GDFC_NUM_FETS-1:0]  ds_s;
    logic [GDFC_NUM_FETS-1:0]  gs_s;
    logic [GDFC_NUM_SENSE-1:0] sa_s;
    logic                      overtemp_shutdown_s;
    logic                      otw_s;
    logic                      pump_s;
    logic                      supply_undervoltage_lockout_s;
    logic                      sleep_s;
    logic [15:0]               frame_word;
    logic                      frame_ok;
    logic                      frame_tag;
    logic [10:0]               status_primary;
    logic [10:0]               status_secondary;
    logic                      commit;
    logic                      write_cmd;
    logic [3:0]                wr_addr;
    logic [10:0]               wr_data;
    logic                      locked;
    logic                      clear_now;
    logic                      single_mode;
    logic                      any_fault;

    // Every input pin but the serial clock, serial data and reset, and the frame tag, cross into the system clock through two stages.
    assign raw_in = {scs_n, frame_tag, phase_c_high_input, phase_c_low_input,
                     drain_source_overcurrent_in, gate_drive_failure_in,
                     sense_amp_overcurrent_in, overtemp_shutdown_in, overtemp_warning_in,
                     charge_pump_undervoltage_in, supply_undervoltage_lockout_in, sleep_in};
    assign {scs_s, tag_s, phase_c_high_input_s, phase_c_low_input_s, ds_s, gs_s, sa_s,
            overtemp_shutdown_s, otw_s, pump_s, supply_undervoltage_lockout_s, sleep_s} = syn;

    gdfc_sync #(
        .WIDTH (SYNC_W)
    ) u_sync (
        .clk      (clk),
        .rst_b    (rst_b),
        .async_in (raw_in),
        .sync_out (syn)
    );

    // The serial link runs on the serial clock and reads only the frozen image.
    gdfc_spi_link u_link (
        .sclk       (sclk),
        .rst_b      (rst_b),
        .scs_n      (scs_n),
        .sdi        (sdi),
        .sdo        (sdo),
        .sdo_oe_n   (sdo_oe_n),
        .reg_image  (cur.snapshot),
        .frame_word (frame_word),
        .frame_ok   (frame_ok),
        .frame_tag  (frame_tag)
    );

    // Status words are assembled from the held flags.
    assign status_primary = {cur.summary, |cur.ds_flags, |cur.gs_flags,
                             cur.supply_uv, cur.overtemp_shutdown, cur.ds_flags};
    assign status_secondary = {cur.sa_flags, cur.overtemp_warning, cur.pump_uv, cur.gs_flags};

    // A frame counts once its select has gone high, with a fresh tag and 16 bits.
    assign commit    = scs_s & ~cur.scs_prev & (tag_s != cur.tag_seen) & frame_ok;
    assign write_cmd = commit & ~frame_word[BIT_FRAME_READ];
    assign wr_addr   = frame_word[BIT_ADDR_HI:BIT_ADDR_LO];
    assign wr_data   = frame_word[10:0];
    assign locked    = (cur.lock == LOCK_ENGAGE);
    assign clear_now = cur.setup[BIT_CLEAR];

    // Flag, control and output update.
    always_comb begin
        next_cur          = cur;
        next_cur.scs_prev = scs_s;
        if (scs_s & ~cur.scs_prev) begin
            next_cur.tag_seen = tag_s;
        end
        // The clear bit lives for one cycle only.
        next_cur.setup[BIT_CLEAR] = 1'b0;
        if (write_cmd && wr_addr == ADDR_DRIVE_SETUP) begin
            if (locked) begin
                next_cur.setup = (cur.setup & ~LOCKED_WRITE_MASK)
                               | (wr_data & LOCKED_WRITE_MASK);
            end else begin
                next_cur.setup = wr_data;
            end
        end
        if (write_cmd && wr_addr == ADDR_LOCK_SETUP) begin
            if (locked && wr_data[BIT_LOCK_HI:BIT_LOCK_LO] == LOCK_RELEASE) begin
                next_cur.lock = LOCK_RELEASE;
            end else if (!locked && wr_data[BIT_LOCK_HI:BIT_LOCK_LO] == LOCK_ENGAGE) begin
                next_cur.lock = LOCK_ENGAGE;
            end
        end
        // Latched flags: a new event wins over a clear in the same cycle.
        next_cur.ds_flags = (cur.ds_flags & ~{GDFC_NUM_FETS{clear_now}}) | ds_s;
        next_cur.sa_flags = (cur.sa_flags & ~{GDFC_NUM_SENSE{clear_now}}) | sa_s;
        if (cur.setup[BIT_GATE_DIS]) begin
            next_cur.gs_flags = '0;
        end else begin
            next_cur.gs_flags = (cur.gs_flags & ~{GDFC_NUM_FETS{clear_now}}) | gs_s;
        end
        next_cur.overtemp_shutdown      = overtemp_shutdown_s;
        next_cur.overtemp_warning       = otw_s;
        next_cur.pump_uv   = pump_s & ~cur.setup[BIT_PUMP_UV_DIS];
        next_cur.supply_uv = 1'b0;
        // Sleep or supply undervoltage puts every register back to default, apart from the undervoltage flag and summary, which undervoltage sets.
        if (sleep_s || supply_undervoltage_lockout_s) begin
            next_cur.ds_flags  = '0;
            next_cur.gs_flags  = '0;
            next_cur.sa_flags  = '0;
            next_cur.overtemp_shutdown      = 1'b0;
            next_cur.overtemp_warning       = 1'b0;
            next_cur.pump_uv   = 1'b0;
            next_cur.supply_uv = supply_undervoltage_lockout_s;
            next_cur.setup     = DRIVE_SETUP_RESET;
            next_cur.lock      = LOCK_RESET;
        end
        any_fault = (|next_cur.ds_flags) | (|next_cur.gs_flags) | (|next_cur.sa_flags)
                  | next_cur.overtemp_shutdown | next_cur.pump_uv | next_cur.supply_uv
                  | (next_cur.overtemp_warning & next_cur.setup[BIT_OTW_REPORT]);
        next_cur.summary = any_fault;
        next_cur.alarm_n = ~any_fault;
        // Outputs toward the gate stage.
        single_mode        = (next_cur.setup[BIT_MODE_HI:BIT_MODE_LO] == MODE_SINGLE_INPUT);
        next_cur.scheme    = next_cur.setup[BIT_MODE_HI:BIT_MODE_LO];
        next_cur.gates_off = next_cur.setup[BIT_COAST];
        next_cur.brake     = single_mode & (next_cur.setup[BIT_BRAKE] | phase_c_low_input_s);
        next_cur.direction = single_mode & (next_cur.setup[BIT_DIRECTION] | phase_c_high_input_s);
        next_cur.freewheel = single_mode & next_cur.setup[BIT_RECTIFY];
        // The read image refreshes only while no frame is running.
        if (scs_s) begin
            next_cur.snapshot = {cur.setup, status_secondary, status_primary};
        end
    end

    // One register stage for all state; everything resets to its default.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cur          <= '0;
            cur.setup    <= DRIVE_SETUP_RESET;
            cur.lock     <= LOCK_RESET;
            cur.alarm_n  <= 1'b1;
            cur.scs_prev <= 1'b1;
        end else begin
            cur <= next_cur;
        end
    end

    assign alarm_out_n      = cur.alarm_n;
    assign gates_off        = cur.gates_off;
    assign low_side_brake   = cur.brake;
    assign rotate_direction = cur.direction;
    assign async_freewheel  = cur.freewheel;
    assign pwm_scheme       = cur.scheme;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    a_alarm_mirror: assert property (alarm_out_n == ~status_primary[BIT_FAULT_SUMMARY])
        else $error("alarm pin differs from summary bit");
    a_ds_summary: assert property (status_primary[BIT_DS_OCP] == |status_primary[5:0])
        else $error("overcurrent summary differs from per-transistor flags");
    a_gate_summary: assert property (status_primary[BIT_GATE_FAILURE] == |status_secondary[5:0])
        else $error("gate fault summary differs from per-transistor flags");
    a_clear_self: assert property (cur.setup[BIT_CLEAR] |=> !cur.setup[BIT_CLEAR])
        else $error("clear bit did not return to zero");
    a_coast_out: assert property (cur.setup[BIT_COAST] && !sleep_s && !supply_undervoltage_lockout_s && !write_cmd
        |=> gates_off)
        else $error("coast bit did not turn gates off");
    a_lock_hold: assert property (locked && write_cmd && wr_addr == ADDR_DRIVE_SETUP
        |=> cur.setup[10:3] == $past(cur.setup[10:3]))
        else $error("locked control bits changed on write");
    a_ds_latch: assert property (cur.ds_flags[5] && !clear_now && !sleep_s && !supply_undervoltage_lockout_s
        |=> cur.ds_flags[5])
        else $error("latched overcurrent flag dropped without clear");
    a_otw_hidden: assert property (!cur.setup[BIT_OTW_REPORT] && status_primary[9:0] == 10'h000
        && status_secondary[10:8] == 3'h0 && status_secondary[6:0] == 7'h00
        |-> !status_primary[BIT_FAULT_SUMMARY])
        else $error("warning reached summary without report enabled");
    a_pump_mask: assert property (cur.setup[BIT_PUMP_UV_DIS] && $past(cur.setup[BIT_PUMP_UV_DIS])
        |-> !cur.pump_uv)
        else $error("pump undervoltage flagged while disabled");
    a_gate_mask: assert property ($past(cur.setup[BIT_GATE_DIS]) |-> cur.gs_flags == 6'h00)
        else $error("gate fault flagged while disabled");
    a_brake_out: assert property (cur.setup[BIT_MODE_HI:BIT_MODE_LO] == MODE_SINGLE_INPUT
        && cur.setup[BIT_BRAKE] && !sleep_s && !supply_undervoltage_lockout_s && !write_cmd |=> low_side_brake)
        else $error("brake not applied in single-input mode");

endmodule : gdfc_regs

// ### testbench/gdfc_spi_master.sv
`timescale 1ns/1ps
module gdfc_spi_master (
    output logic      sclk,
    output logic      scs_n,
    output logic      sdi,
    input  wire logic sdo
);
    // The link idles with select high and its clock stopped low.
    initial begin
        sclk  = 1'b0;
        scs_n = 1'b1;
        sdi   = 1'b0;
    end
    // Sends n bits MSB first at an 80 ns period and gathers the answer on falling edges.
    task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
        r = 16'h0000;
        #33 scs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            #20 sdi = w[15 - (i % 16)];
            #20 sclk = 1'b1;
            #40 sclk = 1'b0;
            r = {r[14:0], sdo};
        end
        #40 scs_n = 1'b1;
        sdi = ~sdi; // Released data line shows no stale level.
        #500;
    endtask : xfer
endmodule : gdfc_spi_master

// ### testbench/gdfc_regs_tb.sv
`timescale 1ns/1ps
module gdfc_regs_tb;
    import gdfc_pkg::*;
    logic       clk = 1'b0, rst_b = 1'b0, sclk, scs_n, sdi, sdo, sdo_oe_n;
    logic       phase_c_high_input = 1'b0, phase_c_low_input = 1'b0;
    logic [5:0] drain_source_overcurrent_in = 6'h00, gate_drive_failure_in = 6'h00;
    logic [2:0] sense_amp_overcurrent_in = 3'h0;
    logic       overtemp_shutdown_in = 1'b0, overtemp_warning_in = 1'b0, sleep_in = 1'b0;
    logic       charge_pump_undervoltage_in = 1'b0, supply_undervoltage_lockout_in = 1'b0;
    logic       alarm_out_n, gates_off, low_side_brake, rotate_direction, async_freewheel;
    logic [1:0] pwm_scheme;
    logic [15:0] r;
    int         err_count = 0, cmp_count = 0, cycles = 0;
    gdfc_regs i_gdfc_regs (.*);
    gdfc_spi_master i_gdfc_spi_master (.sclk(sclk), .scs_n(scs_n), .sdi(sdi), .sdo(sdo));
    // The system clock toggles every half period of 10 ns.
    always #10 clk = ~clk;
    // A hung run is cut short after a generous cycle budget.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            stop_test();
        end
    end
    // Compares one value and reports a mismatch at once.
    task automatic chk(input logic [10:0] got, input logic [10:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Writes one register over the serial link.
    task automatic wr(input logic [3:0] a, input logic [10:0] d);
        i_gdfc_spi_master.xfer({1'b0, a, d}, 16, r);
    endtask : wr
    // Reads one register once pin changes have crossed the synchronisers.
    task automatic rd(input logic [3:0] a, input logic [10:0] e);
        repeat (6) @(negedge clk);
        chk({10'h000, sdo_oe_n}, 11'h001);
        i_gdfc_spi_master.xfer({1'b1, a, 11'h000}, 16, r);
        chk(r[10:0], e);
    endtask : rd
    // Checks scheme, freewheel, direction, brake, coast and alarm pins together.
    task automatic outs(input logic [6:0] e);
        repeat (6) @(negedge clk);
        chk({4'h0, pwm_scheme, async_freewheel, rotate_direction, low_side_brake, gates_off,
             alarm_out_n}, {4'h0, e});
    endtask : outs
    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : stop_test
    // Main sequence of register accesses and pin checks.
    initial begin
        repeat (6) @(negedge clk);
        rst_b = 1'b1;
        for (int a = 0; a < 4; a++) rd(a[3:0], 11'h000);
        outs(7'h01);
        wr(4'h2, 11'h4DE);
        rd(4'h2, 11'h4DE);
        outs(7'h5F);
        for (int m = 0; m < 4; m++) begin
            wr(4'h2, {4'h0, m[1:0], 5'h00});
            outs({m[1:0], 5'h01});
        end
        wr(4'h2, 11'h040);
        @(negedge clk) phase_c_high_input = 1'b1;
        phase_c_low_input = 1'b1;
        outs(7'h4D);
        @(negedge clk) phase_c_high_input = 1'b0;
        phase_c_low_input = 1'b0;
        wr(4'h3, 11'h600);
        wr(4'h2, 11'h0BE);
        rd(4'h2, 11'h046);
        wr(4'h3, 11'h300);
        wr(4'h2, 11'h000);
        rd(4'h2, 11'h000);
        @(negedge clk) drain_source_overcurrent_in = 6'h20;
        rd(4'h0, 11'h620);
        outs(7'h00);
        @(negedge clk) drain_source_overcurrent_in = 6'h00;
        rd(4'h0, 11'h620);
        wr(4'h2, 11'h001);
        rd(4'h0, 11'h000);
        rd(4'h2, 11'h000);
        @(negedge clk) gate_drive_failure_in = 6'h01;
        rd(4'h1, 11'h001);
        rd(4'h0, 11'h500);
        @(negedge clk) gate_drive_failure_in = 6'h00;
        wr(4'h2, 11'h100);
        rd(4'h1, 11'h000);
        @(negedge clk) gate_drive_failure_in = 6'h01;
        rd(4'h1, 11'h000);
        @(negedge clk) gate_drive_failure_in = 6'h00;
        sense_amp_overcurrent_in = 3'h4;
        wr(4'h2, 11'h000);
        rd(4'h1, 11'h400);
        @(negedge clk) sense_amp_overcurrent_in = 3'h0;
        overtemp_shutdown_in = 1'b1;
        wr(4'h2, 11'h001);
        rd(4'h0, 11'h440);
        @(negedge clk) overtemp_shutdown_in = 1'b0;
        overtemp_warning_in = 1'b1;
        rd(4'h1, 11'h080);
        outs(7'h01);
        wr(4'h2, 11'h080);
        outs(7'h00);
        rd(4'h0, 11'h400);
        @(negedge clk) overtemp_warning_in = 1'b0;
        charge_pump_undervoltage_in = 1'b1;
        wr(4'h2, 11'h000);
        rd(4'h1, 11'h040);
        wr(4'h2, 11'h200);
        rd(4'h1, 11'h000);
        @(negedge clk) charge_pump_undervoltage_in = 1'b0;
        supply_undervoltage_lockout_in = 1'b1;
        rd(4'h0, 11'h480);
        @(negedge clk) supply_undervoltage_lockout_in = 1'b0;
        rd(4'h2, 11'h000);
        wr(4'h2, 11'h004);
        @(negedge clk) sleep_in = 1'b1;
        repeat (6) @(negedge clk);
        sleep_in = 1'b0;
        rd(4'h2, 11'h000);
        wr(4'h0, 11'h7FF);
        wr(4'h1, 11'h7FF);
        rd(4'h0, 11'h000);
        rd(4'h1, 11'h000);
        i_gdfc_spi_master.xfer({1'b0, ADDR_DRIVE_SETUP, 11'h004}, 15, r);
        i_gdfc_spi_master.xfer({1'b0, ADDR_DRIVE_SETUP, 11'h004}, 17, r);
        rd(4'h2, 11'h000);
        rd(4'h5, 11'h000);
        stop_test();
    end
endmodule : gdfc_regs_tb
